//--- src/dfci_pkg.sv
// shared constants and carriers for the fieldbus command interpreter
package dfci_pkg;

  // instruction codes, data keys and selector values
  localparam logic [7:0]  INSTR_RD_ACCEL   = 8'h07;
  localparam logic [7:0]  INSTR_FAULT_RD   = 8'h74;
  localparam logic [7:0]  INSTR_WR_ACCEL   = 8'h87;
  localparam logic [7:0]  INSTR_OPMODE_WR  = 8'hFB;
  localparam logic [7:0]  INSTR_RESET      = 8'hFD;
  localparam logic [15:0] DATA_NET_OP      = 16'h0000;
  localparam logic [15:0] DATA_RESET_KEY   = 16'h9696;
  localparam logic [15:0] MON_OUT_FREQ     = 16'h0001;
  localparam logic [7:0]  EXT_PAGE_BASE    = 8'h00;
  localparam logic [7:0]  COMM_RESET_ANY   = 8'h00;
  localparam logic [7:0]  STARTUP_EXTERNAL = 8'h00;

  // reply codes
  localparam logic [15:0] REPLY_OK         = 16'h0000;
  localparam logic [15:0] REPLY_BAD_CODE   = 16'h0001;
  localparam logic [15:0] REPLY_BAD_MODE   = 16'h0002;
  localparam logic [15:0] REPLY_BAD_DATA   = 16'h0003;

  // reset values
  localparam logic [15:0] ACCEL_RST        = 16'h0032;
  localparam logic [15:0] FREQ_RST         = 16'h0000;

  // request bits from the master
  typedef struct packed {
    logic freq_set_cmd_volatile;
    logic freq_set_cmd_nonvolatile;
    logic instr_exec_request;
    logic error_reset_request;
  } dfci_req_s;

  // words written by the master
  typedef struct packed {
    logic [15:0] monitor_code;
    logic [15:0] set_freq;
    logic [15:0] instr_code_word;
    logic [15:0] instr_data_word;
  } dfci_wr_s;

  // completion bits to the master
  typedef struct packed {
    logic freq_set_done_volatile;
    logic freq_set_done_nonvolatile;
    logic instr_exec_done;
    logic error_reset_done;
  } dfci_done_s;

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} dfci_hs_e;

endpackage : dfci_pkg

//--- src/dfci_handshake.sv
// request/acknowledge handshake for one request bit
`timescale 1ns/1ps
module dfci_handshake
  import dfci_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic req,
  input  wire logic finished,
  output logic      start,
  output logic      done
);

  typedef struct packed {
    dfci_hs_e st;
    logic     done;
  } dfci_hs_state_s;

  dfci_hs_state_s s_q;
  dfci_hs_state_s s_d;

  // start fires once per rising request; done holds until request drops
  always_comb
  begin
    s_d   = s_q;
    start = 1'b0;
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (req)
        begin
          start  = 1'b1;
          s_d.st = ST_BUSY;
        end
      end
      ST_BUSY:
      begin
        if (finished)
        begin
          s_d.st   = ST_DONE;
          s_d.done = 1'b1;
        end
      end
      ST_DONE:
      begin
        if (!req)
        begin
          s_d.st   = ST_IDLE;
          s_d.done = 1'b0;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_q <= '{st: ST_IDLE, done: 1'b0};
    else
      s_q <= s_d;
  end

  assign done = s_q.done;

endmodule : dfci_handshake

//--- src/dfci_nv_writer.sv
// one-shot writer to non-volatile frequency storage
`timescale 1ns/1ps
module dfci_nv_writer
  import dfci_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [15:0] value,
  output logic             nv_wr_stb,
  output logic [15:0]      nv_wr_data,
  output logic             finished
);

  typedef struct packed {
    logic        stb;
    logic [15:0] data;
  } dfci_nv_state_s;

  dfci_nv_state_s s_q;
  dfci_nv_state_s s_d;

  // value captured only at start; later changes are never written
  always_comb
  begin
    s_d     = s_q;
    s_d.stb = start;
    if (start)
      s_d.data = value;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_q <= '{stb: 1'b0, data: FREQ_RST};
    else
      s_q <= s_d;
  end

  assign nv_wr_stb  = s_q.stb;
  assign nv_wr_data = s_q.data;
  assign finished   = s_q.stb;

endmodule : dfci_nv_writer

//--- src/dfci_top.sv
// fieldbus command interpreter inside the inverter
`timescale 1ns/1ps
module dfci_top
  import dfci_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire dfci_req_s   req,
  input  wire dfci_wr_s    wr,
  input  wire logic [7:0]  link_ext_setting,
  input  wire logic [7:0]  comm_reset_select,
  input  wire logic [7:0]  comm_startup_mode_select,
  input  wire logic        inverter_error,
  input  wire logic [15:0] output_freq,
  input  wire logic [7:0]  fault_record_1,
  input  wire logic [7:0]  fault_record_2,
  output dfci_done_s       done,
  output logic [15:0]      monitor_value,
  output logic [15:0]      read_data,
  output logic [15:0]      reply_code,
  output logic             net_op_mode,
  output logic [15:0]      accel_time_param,
  output logic [15:0]      freq_ram,
  output logic             nv_wr_stb,
  output logic [15:0]      nv_wr_data,
  output logic             inverter_reset
);

  // whole module state in one struct
  typedef struct packed {
    logic [15:0] monitor_value;
    logic [15:0] read_data;
    logic [15:0] reply_code;
    logic        net_op_mode;
    logic [15:0] accel_time_param;
    logic [15:0] freq_ram;
    logic        inverter_reset;
    logic        instr_fin;
    logic        vol_fin;
    logic        err_fin;
    dfci_done_s  done;
  } dfci_top_state_s;

  dfci_top_state_s s_q;
  dfci_top_state_s s_d;

  logic instr_start;
  logic vol_start;
  logic nv_start;
  logic err_start;
  logic nv_fin;
  logic instr_done;
  logic vol_done;
  logic nv_done;
  logic err_done;
  logic [15:0] nv_data;

  // one handshake per request bit
  dfci_handshake u_hs_instr (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .req      (req.instr_exec_request),
    .finished (s_q.instr_fin),
    .start    (instr_start),
    .done     (instr_done)
  );

  dfci_handshake u_hs_vol (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .req      (req.freq_set_cmd_volatile),
    .finished (s_q.vol_fin),
    .start    (vol_start),
    .done     (vol_done)
  );

  dfci_handshake u_hs_nv (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .req      (req.freq_set_cmd_nonvolatile),
    .finished (nv_fin),
    .start    (nv_start),
    .done     (nv_done)
  );

  dfci_handshake u_hs_err (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .req      (req.error_reset_request),
    .finished (s_q.err_fin),
    .start    (err_start),
    .done     (err_done)
  );

  // storage write happens once at the rising edge only
  dfci_nv_writer u_nv (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (nv_start),
    .value      (wr.set_freq),
    .nv_wr_stb  (nv_wr_stb),
    .nv_wr_data (nv_data),
    .finished   (nv_fin)
  );

  // instruction decode, frequency set and reset gating
  always_comb
  begin
    s_d                = s_q;
    s_d.instr_fin      = 1'b0;
    s_d.vol_fin        = 1'b0;
    s_d.err_fin        = 1'b0;
    s_d.inverter_reset = 1'b0;
    s_d.done.freq_set_done_volatile    = vol_done;
    s_d.done.freq_set_done_nonvolatile = nv_done;
    s_d.done.instr_exec_done           = instr_done;
    s_d.done.error_reset_done          = err_done;

    // monitor refreshes every cycle, raw 0.01 Hz count
    if (wr.monitor_code == MON_OUT_FREQ)
      s_d.monitor_value = output_freq;
    else
      s_d.monitor_value = 16'h0000;

    // volatile set: word already in 0.01 Hz units
    if (vol_start)
    begin
      s_d.freq_ram = wr.set_freq;
      s_d.vol_fin  = 1'b1;
    end
    // non-volatile path writes RAM too, same captured value
    if (nv_start)
      s_d.freq_ram = wr.set_freq;

    // code taken from third word, data from fourth
    if (instr_start)
    begin
      s_d.instr_fin  = 1'b1;
      s_d.reply_code = REPLY_OK;
      unique case (wr.instr_code_word[7:0])
        INSTR_OPMODE_WR:
        begin
          if (wr.instr_data_word == DATA_NET_OP)
            s_d.net_op_mode = 1'b1;
          else
            s_d.reply_code = REPLY_BAD_DATA;
        end
        INSTR_RD_ACCEL:
        begin
          // page must be the base page for low-numbered parameters
          if (link_ext_setting == EXT_PAGE_BASE)
            s_d.read_data = s_q.accel_time_param;
          else
            s_d.reply_code = REPLY_BAD_CODE;
        end
        INSTR_WR_ACCEL:
        begin
          if (link_ext_setting == EXT_PAGE_BASE)
            s_d.accel_time_param = wr.instr_data_word;
          else
            s_d.reply_code = REPLY_BAD_CODE;
        end
        INSTR_FAULT_RD:
          s_d.read_data = {fault_record_2, fault_record_1};
        INSTR_RESET:
        begin
          if (wr.instr_data_word != DATA_RESET_KEY)
            s_d.reply_code = REPLY_BAD_DATA;
          else if (comm_startup_mode_select != STARTUP_EXTERNAL || s_q.net_op_mode)
            s_d.inverter_reset = 1'b1;
          else
            s_d.reply_code = REPLY_BAD_MODE;
        end
        default:
          s_d.reply_code = REPLY_BAD_CODE;
      endcase
    end

    // error reset bit: needs an error unless selection is zero
    if (err_start)
    begin
      s_d.err_fin = 1'b1;
      if (comm_reset_select == COMM_RESET_ANY)
        s_d.inverter_reset = 1'b1;
      else if (inverter_error)
        s_d.inverter_reset = 1'b1;
    end

    // a reset drops back to external mode unless startup selects network
    if (s_q.inverter_reset)
      s_d.net_op_mode = (comm_startup_mode_select != STARTUP_EXTERNAL);
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_q                  <= '0;
      s_q.accel_time_param <= ACCEL_RST;
      s_q.freq_ram         <= FREQ_RST;
      s_q.reply_code       <= REPLY_OK;
    end
    else
      s_q <= s_d;
  end

  // outputs straight from flops
  assign done             = s_q.done;
  assign monitor_value    = s_q.monitor_value;
  assign read_data        = s_q.read_data;
  assign reply_code       = s_q.reply_code;
  assign net_op_mode      = s_q.net_op_mode;
  assign accel_time_param = s_q.accel_time_param;
  assign freq_ram         = s_q.freq_ram;
  assign nv_wr_data       = nv_data;
  assign inverter_reset   = s_q.inverter_reset;

endmodule : dfci_top

//--- tb/dfci_checker.sv
// port assertions for the command interpreter
`timescale 1ns/1ps
module dfci_checker
  import dfci_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire dfci_req_s   req,
  input wire dfci_wr_s    wr,
  input wire logic [7:0]  link_ext_setting,
  input wire logic [7:0]  comm_reset_select,
  input wire logic        inverter_error,
  input wire logic [7:0]  fault_record_1,
  input wire logic [7:0]  fault_record_2,
  input wire dfci_done_s  done,
  input wire logic [15:0] read_data,
  input wire logic [15:0] reply_code,
  input wire logic        net_op_mode,
  input wire logic [15:0] accel_time_param,
  input wire logic [15:0] freq_ram,
  input wire logic        nv_wr_stb,
  input wire logic [15:0] nv_wr_data,
  input wire logic        inverter_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // completion follows the request level
  a_done_falls: assert property (
    done.instr_exec_done && !req.instr_exec_request |-> ##[1:2] !done.instr_exec_done)
    else $error("done stuck");
  a_done_cause: assert property (
    $rose(done.instr_exec_done) |-> $past(req.instr_exec_request, 2)) else $error("done early");
  // held command must not store again; a fast master may re-store five cycles on
  a_nv_pulse: assert property (
    nv_wr_stb |=> !nv_wr_stb [*4]) else $error("store repeated");
  a_nv_held: assert property (
    req.freq_set_cmd_nonvolatile && done.freq_set_done_nonvolatile |-> !nv_wr_stb)
    else $error("store while command held");
  a_nv_ram: assert property (
    nv_wr_stb |-> nv_wr_data == freq_ram) else $error("store differs from ram");
  a_reset_refuse: assert property (
    req.error_reset_request && !inverter_error && comm_reset_select != COMM_RESET_ANY
    && !req.instr_exec_request |=> !inverter_reset) else $error("reset without error");
  // results checked when completion rises
  a_fault_pack: assert property (
    $rose(done.instr_exec_done) && wr.instr_code_word[7:0] == INSTR_FAULT_RD
    |-> read_data == {fault_record_2, fault_record_1}) else $error("fault pack");
  a_opmode_ok: assert property (
    $rose(done.instr_exec_done) && wr.instr_code_word[7:0] == INSTR_OPMODE_WR
    && wr.instr_data_word == DATA_NET_OP |-> reply_code == REPLY_OK && net_op_mode)
    else $error("mode write");
  a_accel_wr: assert property (
    $rose(done.instr_exec_done) && wr.instr_code_word[7:0] == INSTR_WR_ACCEL
    && link_ext_setting == EXT_PAGE_BASE |-> accel_time_param == wr.instr_data_word)
    else $error("accel write");
endmodule : dfci_checker

bind dfci_top dfci_checker dfci_checker_i (.*);

//--- tb/dfci_master.sv
// master station model: words, request bits, handshake
`timescale 1ns/1ps
module dfci_master
  import dfci_pkg::*;
(
  input  wire logic       clk,
  input  wire dfci_done_s done,
  output dfci_req_s       req,
  output dfci_wr_s        wr
);
  int lost = 0;
  initial
  begin
    req = '0;
    wr  = '0;
  end
  // d extra hold cycles model a slow master
  task automatic hs(input int b, input int d);
    int n;
    n = 0;
    req[b] = 1'b1;
    while (done[b] !== 1'b1 && n < 30)
    begin
      @(negedge clk);
      n++;
    end
    // a completion that never comes must not pass silently
    if (done[b] !== 1'b1)
      lost++;
    // held store command: new data must be ignored
    if (b == 2 && d > 0)
      wr.set_freq = ~wr.set_freq;
    repeat (d) @(negedge clk);
    req[b] = 1'b0;
    while (done[b] !== 1'b0 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    if (done[b] !== 1'b0)
      lost++;
    @(negedge clk);
  endtask : hs
  task automatic instr(input logic [7:0] c, input logic [15:0] v, input int d);
    wr.instr_code_word = {8'h00, c};
    wr.instr_data_word = v;
    hs(1, d);
  endtask : instr
endmodule : dfci_master

//--- tb/tb.sv
// self-checking bench for the command interpreter
`timescale 1ns/1ps
module tb;
  import dfci_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  link_ext_setting = 8'h00;
  logic [7:0]  comm_reset_select = 8'h01;
  logic [7:0]  comm_startup_mode_select = 8'h00;
  logic        inverter_error = 1'b0;
  logic [15:0] output_freq = 16'h0000;
  logic [7:0]  fault_record_1 = 8'h00;
  logic [7:0]  fault_record_2 = 8'h00;
  logic [31:0] seed = 32'hF20E;
  dfci_req_s   req;
  dfci_wr_s    wr;
  dfci_done_s  done;
  logic [15:0] monitor_value, read_data, reply_code, accel_time_param, freq_ram, nv_wr_data;
  logic        net_op_mode, nv_wr_stb, inverter_reset;
  int          bad_count = 0, comparisons = 0, n_rst = 0, n_nv = 0, r0, m_net = 0;
  logic [15:0] m_accel = ACCEL_RST, v;
  int          cs [3][3] = '{'{1, 0, 0}, '{1, 1, 1}, '{0, 0, 1}};
  initial forever #2.5 clk = ~clk;
  dfci_top dfci_top_i (.clk(clk), .sys_rst(sys_rst), .req(req), .wr(wr),
    .link_ext_setting(link_ext_setting), .comm_reset_select(comm_reset_select),
    .comm_startup_mode_select(comm_startup_mode_select), .inverter_error(inverter_error),
    .output_freq(output_freq), .fault_record_1(fault_record_1),
    .fault_record_2(fault_record_2), .done(done), .monitor_value(monitor_value),
    .read_data(read_data), .reply_code(reply_code), .net_op_mode(net_op_mode),
    .accel_time_param(accel_time_param), .freq_ram(freq_ram), .nv_wr_stb(nv_wr_stb),
    .nv_wr_data(nv_wr_data), .inverter_reset(inverter_reset));
  dfci_master dfci_master_i (.clk(clk), .done(done), .req(req), .wr(wr));
  // pulse counters, one per strobe
  always @(posedge clk)
  begin
    if (inverter_reset === 1'b1) n_rst++;
    if (nv_wr_stb === 1'b1) n_nv++;
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  // random hold keeps the master slow at times
  task automatic ins(input logic [7:0] c, input logic [15:0] d, input logic [15:0] rc);
    dfci_master_i.instr(c, d, int'(xs() & 32'h3));
    chk(reply_code, rc);
  endtask : ins
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    #100000;
    bad_count++;
    test_done();
  end
  initial
  begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk(accel_time_param, ACCEL_RST);
    ins(INSTR_OPMODE_WR, DATA_NET_OP, REPLY_OK);
    m_net = 1;
    chk(16'(net_op_mode), 16'(m_net));
    ins(INSTR_RD_ACCEL, 16'h0000, REPLY_OK);
    chk(read_data, m_accel);
    ins(INSTR_WR_ACCEL, 16'd30, REPLY_OK);
    m_accel = 16'd30;
    ins(INSTR_RD_ACCEL, 16'h0000, REPLY_OK);
    chk(read_data, m_accel);
    link_ext_setting = 8'h08;
    dfci_master_i.instr(INSTR_WR_ACCEL, 16'd99, 0);
    chk(16'(reply_code == REPLY_OK), 16'h0000);
    chk(accel_time_param, m_accel);
    link_ext_setting = EXT_PAGE_BASE;
    $display("test params done");
    {fault_record_2, fault_record_1} = 16'(xs());
    ins(INSTR_FAULT_RD, 16'h0000, REPLY_OK);
    chk(read_data, {fault_record_2, fault_record_1});
    output_freq = 16'(xs());
    // other monitor codes read zero even with a live frequency
    repeat (2) @(negedge clk);
    chk(monitor_value, 16'h0000);
    dfci_master_i.wr.monitor_code = MON_OUT_FREQ;
    repeat (3) @(negedge clk);
    chk(monitor_value, output_freq);
    $display("test reads done");
    // plain value then random value to volatile storage
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 16'(xs()) : 16'd5000;
      dfci_master_i.wr.set_freq = v;
      r0 = n_nv;
      dfci_master_i.hs(3, i);
      chk(freq_ram, v);
      chk(16'(n_nv - r0), 16'h0000);
    end
    v = 16'(xs());
    dfci_master_i.wr.set_freq = v;
    r0 = n_nv;
    dfci_master_i.hs(2, 4);
    chk(16'(n_nv - r0), 16'h0001);
    chk(nv_wr_data, v);
    chk(freq_ram, v);
    $display("test frequency done");
    // error reset: selection, error, expected pulse
    foreach (cs[i])
    begin
      comm_reset_select = 8'(cs[i][0]);
      inverter_error = cs[i][1][0];
      r0 = n_rst;
      dfci_master_i.hs(0, 0);
      chk(16'(n_rst - r0), 16'(cs[i][2]));
      inverter_error = 1'b0;
    end
    m_net = 0;
    chk(16'(net_op_mode), 16'(m_net));
    r0 = n_rst;
    ins(INSTR_RESET, DATA_RESET_KEY, REPLY_BAD_MODE);
    comm_startup_mode_select = 8'h01;
    ins(INSTR_RESET, DATA_RESET_KEY, REPLY_OK);
    chk(16'(n_rst - r0), 16'h0001);
    chk(16'(net_op_mode), 16'h0001);
    $display("test resets done");
    // mid-run reset must bring the outputs back to their idle values
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk(accel_time_param, ACCEL_RST);
    chk(freq_ram, FREQ_RST);
    chk(reply_code, REPLY_OK);
    chk(16'(net_op_mode), 16'h0000);
    chk(16'(done), 16'h0000);
    $display("test mid reset done");
    chk(16'(dfci_master_i.lost), 16'h0000);
    test_done();
  end
endmodule : tb
